//--- verilog/dssu_defines.svh
`ifndef DSSU_DEFINES_SVH
`define DSSU_DEFINES_SVH

// clock and line timing
`define DSSU_CLK_PERIOD_NS 8
`define DSSU_BIT_NS        833300
`define DSSU_BIT_CYCLES    (`DSSU_BIT_NS / `DSSU_CLK_PERIOD_NS)

// frame shapes
`define DSSU_RX_DATA_BITS  16
`define DSSU_TX_HALVES     22
`define DSSU_TX_HALF_W     5
`define DSSU_CNT_W         20

// receive word buffer
`define DSSU_WORD_W        16
`define DSSU_FIFO_DEPTH    32

// receive error status fields
`define DSSU_ERR_W         8
`define DSSU_ERR_CODE_BIT  0
`define DSSU_ERR_STOP_BIT  1
`define DSSU_ERR_START_BIT 2

// line idle level
`define DSSU_IDLE_LEVEL    1'b1

`endif

//--- verilog/dssu_pkg.sv
package dssu_pkg;

  // receive decoder states
  typedef enum logic [2:0] {
    DSSU_RX_IDLE  = 3'b000,
    DSSU_RX_FIRST = 3'b001,
    DSSU_RX_MID   = 3'b010,
    DSSU_RX_STOP  = 3'b011,
    DSSU_RX_WAIT  = 3'b100
  } dssu_rx_state_t;

endpackage

//--- verilog/dssu_fifo.sv
`timescale 1ns/1ps

module dssu_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic             mclk_in,
  input  wire logic             rstn_in,
  // fill side
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  // drain side
  output logic                  out_valid_out,
  output logic [WIDTH-1:0]      out_data_out,
  input  wire logic             out_ready_in
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0]      wr_ptr_r;
  logic [AW:0]      wr_ptr_nxt;
  logic [AW:0]      rd_ptr_r;
  logic [AW:0]      rd_ptr_nxt;
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;

  // extra pointer bit tells full from empty
  assign full          = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  assign empty         = (wr_ptr_r == rd_ptr_r);
  assign in_ready_out  = !full;
  assign out_valid_out = !empty;
  assign out_data_out  = mem_r[rd_ptr_r[AW-1:0]];
  assign push          = in_valid_in && !full;
  assign pop           = out_ready_in && !empty;

  // pointer next values
  always_comb begin
    wr_ptr_nxt = push ? wr_ptr_r + 1'b1 : wr_ptr_r;
    rd_ptr_nxt = pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
  end

  // pointer registers
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
    end
  end

  // storage needs no reset, empty flag guards it
  always_ff @(posedge mclk_in) begin
    if (push) begin
      mem_r[wr_ptr_r[AW-1:0]] <= in_data_in;
    end
  end

endmodule // dssu_fifo

//--- verilog/dssu_serial_unit.sv
`timescale 1ns/1ps
`include "dssu_defines.svh"

// What this block does
// - good forward frame stores its 16-bit word and pulses receive-done
// - bad frame pulses receive-error instead and records the cause
// - address byte lands in upper eight bits, data byte in lower
// - forward frame is start bit, address, data, two stop bits; idle high
// - frames are taken only with clock enable and receive enable set
// - writing the transmit byte starts a backward frame with that byte
// - transmit-done pulses once the backward frame has fully left
// - bits are Manchester: rising mid-bit edge is one, falling is zero
// - each bit lasts 833.3 us, plus or minus ten percent
// - every byte is sent and received most significant bit first
module dssu_serial_unit #(
  parameter int BIT_CYCLES = `DSSU_BIT_CYCLES,
  parameter int FIFO_DEPTH = `DSSU_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                    mclk_in,
  input  wire logic                    rstn_in,
  // software enables
  input  wire logic                    unit_clock_enable_in,
  input  wire logic                    rx_enable_in,
  input  wire logic                    tx_enable_in,
  // transmit byte buffer write
  input  wire logic                    tx_byte_wr_in,
  input  wire logic [7:0]              tx_byte_in,
  // receive word buffer read side
  output logic [`DSSU_WORD_W-1:0]      rx_word_out,
  output logic                         rx_word_valid_out,
  input  wire logic                    rx_word_rd_in,
  // status and events
  output logic [`DSSU_ERR_W-1:0]       rx_error_status_out,
  output logic                         rx_done_irq_out,
  output logic                         rx_error_irq_out,
  output logic                         tx_done_irq_out,
  output logic                         tx_busy_out,
  // bus line
  input  wire logic                    line_rx_pin_in,
  output logic                         line_tx_pin_out
);
  localparam int CW       = `DSSU_CNT_W;
  localparam int HALF     = BIT_CYCLES / 2;
  localparam int QUART    = BIT_CYCLES / 4;
  localparam int Q3       = HALF + QUART;
  localparam int STOP_END = 2 * BIT_CYCLES + QUART;

  // line input synchroniser
  logic rx_meta_r;
  logic rx_sync_r;

  // receiver state
  dssu_pkg::dssu_rx_state_t rx_state_r;
  dssu_pkg::dssu_rx_state_t rx_state_nxt;
  logic [CW-1:0]               rx_cnt_r;
  logic [CW-1:0]               rx_cnt_nxt;
  logic [4:0]                  rx_idx_r;
  logic [4:0]                  rx_idx_nxt;
  logic                        rx_half_r;
  logic                        rx_half_nxt;
  logic [`DSSU_WORD_W-1:0]     rx_word_r;
  logic [`DSSU_WORD_W-1:0]     rx_word_nxt;
  logic [`DSSU_ERR_W-1:0]      rx_err_r;
  logic [`DSSU_ERR_W-1:0]      rx_err_nxt;
  logic                        rx_done_r;
  logic                        rx_done_nxt;
  logic                        rx_fail_r;
  logic                        rx_fail_nxt;
  logic                        rx_push;
  logic [`DSSU_WORD_W-1:0]     rx_push_word;
  logic                        rx_on;
  logic                        fifo_ready;

  // transmitter state
  logic                        tx_busy_r;
  logic                        tx_busy_nxt;
  logic [`DSSU_TX_HALVES-1:0]  tx_pat_r;
  logic [`DSSU_TX_HALVES-1:0]  tx_pat_nxt;
  logic [`DSSU_TX_HALF_W-1:0]  tx_halves_r;
  logic [`DSSU_TX_HALF_W-1:0]  tx_halves_nxt;
  logic [CW-1:0]               tx_div_r;
  logic [CW-1:0]               tx_div_nxt;
  logic                        tx_pin_r;
  logic                        tx_pin_nxt;
  logic                        tx_done_r;
  logic                        tx_done_nxt;
  logic                        tx_on;
  logic                        tx_tick;

  // whole backward frame as half-bit levels, first half leftmost
  function automatic logic [`DSSU_TX_HALVES-1:0] dssu_manch(input logic [7:0] b);
    logic [`DSSU_TX_HALVES-1:0] p;
    p = '0;
    p[21:20] = 2'b01;
    for (int i = 7; i >= 0; i--) begin
      p[2*i+5 -: 2] = {~b[i], b[i]};
    end
    p[3:0] = 4'hf;
    return p;
  endfunction

  // two flops before anything looks at the line
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      rx_meta_r <= `DSSU_IDLE_LEVEL;
      rx_sync_r <= `DSSU_IDLE_LEVEL;
    end else begin
      rx_meta_r <= line_rx_pin_in;
      rx_sync_r <= rx_meta_r;
    end
  end

  assign rx_on = unit_clock_enable_in && rx_enable_in;

  // receive decoder next state; resyncs on every mid-bit edge so drift cannot pile up
  always_comb begin
    logic [`DSSU_ERR_W-1:0] cause;
    cause        = '0;
    rx_state_nxt = rx_state_r;
    rx_cnt_nxt   = rx_cnt_r + 1'b1;
    rx_idx_nxt   = rx_idx_r;
    rx_half_nxt  = rx_half_r;
    rx_word_nxt  = rx_word_r;
    rx_err_nxt   = rx_err_r;
    rx_done_nxt  = 1'b0;
    rx_fail_nxt  = 1'b0;
    rx_push      = 1'b0;
    rx_push_word = rx_word_r;
    if (!rx_on) begin
      rx_state_nxt = dssu_pkg::DSSU_RX_IDLE;
      rx_cnt_nxt   = '0;
    end else begin
      case (rx_state_r)
        dssu_pkg::DSSU_RX_IDLE: begin
          rx_cnt_nxt = '0;
          // a full buffer holds off arming, so no word is ever dropped
          if (!rx_sync_r && fifo_ready) begin
            rx_state_nxt = dssu_pkg::DSSU_RX_FIRST;
            rx_idx_nxt   = '0;
            rx_word_nxt  = '0;
          end
        end
        dssu_pkg::DSSU_RX_FIRST: begin
          // quarter into start bit, else three quarters past last mid edge
          if (rx_cnt_r == CW'((rx_idx_r == 5'h00) ? QUART - 1 : Q3 - 1)) begin
            rx_half_nxt  = rx_sync_r;
            rx_cnt_nxt   = '0;
            rx_state_nxt = dssu_pkg::DSSU_RX_MID;
          end
        end
        dssu_pkg::DSSU_RX_MID: begin
          if (rx_sync_r != rx_half_r) begin
            rx_cnt_nxt = '0;
            if (rx_idx_r == 5'h00) begin
              if (!rx_sync_r) begin
                cause[`DSSU_ERR_START_BIT] = 1'b1;
              end else begin
                rx_idx_nxt   = 5'h01;
                rx_state_nxt = dssu_pkg::DSSU_RX_FIRST;
              end
            end else begin
              // address first then data, msb first: address ends up on top
              rx_word_nxt = {rx_word_r[`DSSU_WORD_W-2:0], rx_sync_r};
              rx_idx_nxt  = rx_idx_r + 1'b1;
              rx_state_nxt = (rx_idx_r == 5'(`DSSU_RX_DATA_BITS)) ?
                             dssu_pkg::DSSU_RX_STOP : dssu_pkg::DSSU_RX_FIRST;
            end
          end else if (rx_cnt_r == CW'(HALF - 1)) begin
            cause[`DSSU_ERR_CODE_BIT] = 1'b1;
          end
        end
        dssu_pkg::DSSU_RX_STOP: begin
          // both stop bits must read high; the last data half may still be low
          if (rx_cnt_r >= CW'(Q3) && !rx_sync_r) begin
            cause[`DSSU_ERR_STOP_BIT] = 1'b1;
          end else if (rx_cnt_r == CW'(STOP_END - 1)) begin
            rx_push      = 1'b1;
            rx_done_nxt  = 1'b1;
            rx_state_nxt = dssu_pkg::DSSU_RX_IDLE;
          end
        end
        dssu_pkg::DSSU_RX_WAIT: begin
          // rearm only after a whole bit of quiet line
          if (!rx_sync_r) begin
            rx_cnt_nxt = '0;
          end else if (rx_cnt_r == CW'(BIT_CYCLES - 1)) begin
            rx_state_nxt = dssu_pkg::DSSU_RX_IDLE;
          end
        end
        default: begin
          rx_state_nxt = dssu_pkg::DSSU_RX_IDLE;
        end
      endcase
      // error path pushes the partial word too, so software has one to discard
      if (cause != '0) begin
        rx_err_nxt   = cause;
        rx_fail_nxt  = 1'b1;
        rx_push      = 1'b1;
        rx_push_word = rx_word_nxt;
        rx_cnt_nxt   = '0;
        rx_state_nxt = dssu_pkg::DSSU_RX_WAIT;
      end
    end
  end

  // receive decoder registers
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      rx_state_r <= dssu_pkg::DSSU_RX_IDLE;
      rx_cnt_r   <= '0;
      rx_idx_r   <= '0;
      rx_half_r  <= 1'b0;
      rx_word_r  <= '0;
      rx_err_r   <= '0;
      rx_done_r  <= 1'b0;
      rx_fail_r  <= 1'b0;
    end else begin
      rx_state_r <= rx_state_nxt;
      rx_cnt_r   <= rx_cnt_nxt;
      rx_idx_r   <= rx_idx_nxt;
      rx_half_r  <= rx_half_nxt;
      rx_word_r  <= rx_word_nxt;
      rx_err_r   <= rx_err_nxt;
      rx_done_r  <= rx_done_nxt;
      rx_fail_r  <= rx_fail_nxt;
    end
  end

  // receive word buffer
  dssu_fifo #(
    .WIDTH (`DSSU_WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .mclk_in       (mclk_in),
    .rstn_in       (rstn_in),
    .in_valid_in   (rx_push),
    .in_data_in    (rx_push_word),
    .in_ready_out  (fifo_ready),
    .out_valid_out (rx_word_valid_out),
    .out_data_out  (rx_word_out),
    .out_ready_in  (rx_word_rd_in)
  );

  assign tx_on   = unit_clock_enable_in && tx_enable_in;
  assign tx_tick = tx_busy_r && (tx_div_r == CW'(HALF - 1));   // half-bit enable pulse

  // transmitter next state; a write while busy is dropped, not queued
  always_comb begin
    tx_busy_nxt   = tx_busy_r;
    tx_pat_nxt    = tx_pat_r;
    tx_halves_nxt = tx_halves_r;
    tx_div_nxt    = tx_div_r;
    tx_done_nxt   = 1'b0;
    if (!tx_on) begin
      tx_busy_nxt = 1'b0;
      tx_div_nxt  = '0;
    end else if (tx_busy_r) begin
      tx_div_nxt = tx_div_r + 1'b1;
      if (tx_tick) begin
        tx_div_nxt    = '0;
        tx_pat_nxt    = {tx_pat_r[`DSSU_TX_HALVES-2:0], `DSSU_IDLE_LEVEL};
        tx_halves_nxt = tx_halves_r + 1'b1;
        if (tx_halves_r == `DSSU_TX_HALF_W'(`DSSU_TX_HALVES - 1)) begin
          tx_busy_nxt = 1'b0;
          tx_done_nxt = 1'b1;
        end
      end
    end else if (tx_byte_wr_in) begin
      tx_busy_nxt   = 1'b1;
      tx_pat_nxt    = dssu_manch(tx_byte_in);
      tx_halves_nxt = '0;
      tx_div_nxt    = '0;
    end
    tx_pin_nxt = tx_busy_nxt ? tx_pat_nxt[`DSSU_TX_HALVES-1] : `DSSU_IDLE_LEVEL;
  end

  // transmitter registers; pin is a flop so it never glitches
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      tx_busy_r   <= 1'b0;
      tx_pat_r    <= '1;
      tx_halves_r <= '0;
      tx_div_r    <= '0;
      tx_pin_r    <= `DSSU_IDLE_LEVEL;
      tx_done_r   <= 1'b0;
    end else begin
      tx_busy_r   <= tx_busy_nxt;
      tx_pat_r    <= tx_pat_nxt;
      tx_halves_r <= tx_halves_nxt;
      tx_div_r    <= tx_div_nxt;
      tx_pin_r    <= tx_pin_nxt;
      tx_done_r   <= tx_done_nxt;
    end
  end

  // outputs straight from flops
  assign rx_error_status_out = rx_err_r;
  assign rx_done_irq_out     = rx_done_r;
  assign rx_error_irq_out    = rx_fail_r;
  assign tx_done_irq_out     = tx_done_r;
  assign tx_busy_out         = tx_busy_r;
  assign line_tx_pin_out     = tx_pin_r;

endmodule // dssu_serial_unit

//--- tb/dssu_serial_unit_sva.sv
`timescale 1ns/1ps
`include "dssu_defines.svh"

module dssu_serial_unit_sva #(
  parameter int BIT_CYCLES = 40,
  parameter int FIFO_DEPTH = 32
) (
  input wire logic                  mclk_in,
  input wire logic                  rstn_in,
  input wire logic                  unit_clock_enable_in,
  input wire logic                  rx_enable_in,
  input wire logic                  tx_enable_in,
  input wire logic                  tx_byte_wr_in,
  input wire logic                  rx_word_valid_out,
  input wire logic [`DSSU_ERR_W-1:0] rx_error_status_out,
  input wire logic                  rx_done_irq_out,
  input wire logic                  rx_error_irq_out,
  input wire logic                  tx_done_irq_out,
  input wire logic                  tx_busy_out,
  input wire logic                  line_tx_pin_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);

  int tx_cnt_r;
  int tx_cnt_nxt;

  // length of the current backward frame in cycles
  always_comb begin
    tx_cnt_nxt = tx_busy_out ? tx_cnt_r + 1 : 0;
  end

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) tx_cnt_r <= 0;
    else tx_cnt_r <= tx_cnt_nxt;
  end

  chk_tx_idle_high: assert property (!tx_busy_out |-> line_tx_pin_out)
    else $error("tx pin low while idle");
  chk_tx_start_low: assert property ($rose(tx_busy_out) |-> !line_tx_pin_out)
    else $error("backward frame does not open low");
  chk_wr_starts_frame: assert property (tx_byte_wr_in && !tx_busy_out
    && unit_clock_enable_in && tx_enable_in |=> tx_busy_out)
    else $error("write did not start a frame");
  chk_done_ends_busy: assert property (tx_done_irq_out |-> !tx_busy_out && $past(tx_busy_out))
    else $error("tx done without a finished frame");
  chk_tx_frame_len: assert property (tx_done_irq_out |-> tx_cnt_r == 11 * BIT_CYCLES)
    else $error("backward frame length wrong");
  // a disable may cut a half short; the pin then drops to idle with busy already low
  chk_tx_half_hold: assert property ($changed(line_tx_pin_out) && tx_busy_out
    |=> (!tx_busy_out || $stable(line_tx_pin_out)) [*8])
    else $error("tx half shorter than expected");
  chk_rx_irq_excl: assert property (!(rx_done_irq_out && rx_error_irq_out))
    else $error("done and error together");
  chk_rx_push_word: assert property (rx_done_irq_out |-> rx_word_valid_out)
    else $error("done without a stored word");
  chk_rx_err_cause: assert property (rx_error_irq_out |-> rx_error_status_out != 8'h00)
    else $error("error without a cause");
  chk_rx_gated_off: assert property (!(rx_enable_in && unit_clock_enable_in) [*8] |-> !rx_done_irq_out)
    else $error("frame taken while disabled");

  cov_rx_done: cover property (rx_done_irq_out);
  cov_rx_error: cover property (rx_error_irq_out);
  cov_tx_done: cover property (tx_done_irq_out);
endmodule // dssu_serial_unit_sva

bind dssu_serial_unit dssu_serial_unit_sva #(.BIT_CYCLES(BIT_CYCLES), .FIFO_DEPTH(FIFO_DEPTH)) u_sva (
  .mclk_in(mclk_in), .rstn_in(rstn_in), .unit_clock_enable_in(unit_clock_enable_in),
  .rx_enable_in(rx_enable_in), .tx_enable_in(tx_enable_in), .tx_byte_wr_in(tx_byte_wr_in),
  .rx_word_valid_out(rx_word_valid_out), .rx_error_status_out(rx_error_status_out),
  .rx_done_irq_out(rx_done_irq_out), .rx_error_irq_out(rx_error_irq_out),
  .tx_done_irq_out(tx_done_irq_out), .tx_busy_out(tx_busy_out), .line_tx_pin_out(line_tx_pin_out));

//--- tb/dssu_line_master.sv
`timescale 1ns/1ps

module dssu_line_master #(
  parameter int BIT_CYCLES = 40
) (
  input  wire logic mclk_in,
  output logic      line_out
);
  // bus rests high between frames
  initial line_out = 1'b1;

  // fault 1: stop bits low, fault 2: last data bit has no mid edge
  task automatic send(input logic [15:0] w, input int fault);
    logic [37:0] h;
    h = {2'b01, 32'h0, 4'hf};
    for (int k = 0; k < 16; k++) begin
      h[35-2*k] = ~w[15-k];
      h[34-2*k] = w[15-k];
    end
    if (fault == 1) h[3:0] = 4'h0;
    if (fault == 2) h[5:4] = {2{w[0]}};
    for (int k = 37; k >= 0; k--)
      repeat (BIT_CYCLES / 2) @(posedge mclk_in) line_out <= h[k];
    @(posedge mclk_in) line_out <= 1'b1;
  endtask
endmodule // dssu_line_master

//--- tb/dssu_serial_unit_bench.sv
`timescale 1ns/1ps

module dssu_serial_unit_bench;
  localparam int BIT  = 40;
  localparam int HALF = BIT / 2;
  logic        mclk_in, rstn_in, clk_en, rx_en, tx_en, wr, rd, rxv, rxd, rxe, txd, busy, tx_pin, line;
  logic [7:0]  tx_byte, status;
  logic [15:0] word, w;
  int          err_total, check_count, seed, cyc, n_done, n_err, n_txd, e;
  int          exp_q[$];

  dssu_serial_unit #(.BIT_CYCLES(BIT), .FIFO_DEPTH(32)) dut (
    .mclk_in(mclk_in), .rstn_in(rstn_in), .unit_clock_enable_in(clk_en), .rx_enable_in(rx_en),
    .tx_enable_in(tx_en), .tx_byte_wr_in(wr), .tx_byte_in(tx_byte), .rx_word_out(word),
    .rx_word_valid_out(rxv), .rx_word_rd_in(rd), .rx_error_status_out(status), .rx_done_irq_out(rxd),
    .rx_error_irq_out(rxe), .tx_done_irq_out(txd), .tx_busy_out(busy), .line_rx_pin_in(line),
    .line_tx_pin_out(tx_pin));
  dssu_line_master #(.BIT_CYCLES(BIT)) m (.mclk_in(mclk_in), .line_out(line));

  initial begin
    mclk_in = 1'b0;
    forever #4 mclk_in = ~mclk_in;
  end

  task end_sim();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // event counters and hang guard
  always @(posedge mclk_in) begin
    cyc++;
    if (rxd === 1'b1) n_done++;
    if (rxe === 1'b1) n_err++;
    if (txd === 1'b1) n_txd++;
    if (cyc == 50000) begin
      err_total++;
      end_sim();
    end
  end

  task frame(input logic [15:0] fw, input int fault, input int d, input int er, input logic [7:0] st);
    int d0, e0;
    d0 = n_done;
    e0 = n_err;
    m.send(fw, fault);
    repeat (2 * BIT) @(posedge mclk_in);
    #1;
    chk("rx done count", d[15:0], 16'(n_done - d0));
    chk("rx error count", er[15:0], 16'(n_err - e0));
    if (er > 0) chk("rx error status", {8'h00, st}, {8'h00, status});
  endtask

  task send_tx(input logic [7:0] b);
    logic [21:0] h;
    int t0;
    h = {2'b01, 16'h0, 4'hf};
    for (int k = 0; k < 8; k++) begin
      h[19-2*k] = ~b[7-k];
      h[18-2*k] = b[7-k];
    end
    t0 = n_txd;
    @(posedge mclk_in) begin wr <= 1'b1; tx_byte <= b; end
    @(posedge mclk_in) wr <= 1'b0;
    // a second write mid-frame must be dropped
    for (int k = 0; k < 22; k++)
      for (int j = 0; j < HALF; j++) begin
        @(posedge mclk_in) wr <= (k == 5 && j == 0);
        if (j == HALF / 2) begin
          #1 chk("tx half", {15'h0, h[21-k]}, {15'h0, tx_pin});
        end
      end
    @(posedge mclk_in) #1 chk("tx busy end", 16'h0, {15'h0, busy});
    repeat (2) @(posedge mclk_in);
    #1 chk("tx done count", 16'h1, 16'(n_txd - t0));
  endtask

  initial begin
    seed = 36488;
    {rstn_in, clk_en, rx_en, tx_en, wr, rd, tx_byte} = '0;
    repeat (6) @(posedge mclk_in);
    rstn_in <= 1'b1;
    @(posedge mclk_in) #1 chk("tx idle", 16'h1, {15'h0, tx_pin});
    // either enable missing keeps the receiver deaf
    rx_en <= 1'b1;
    frame(16'h0105, 0, 0, 0, 8'h00);
    clk_en <= 1'b1;
    rx_en <= 1'b0;
    frame(16'h0105, 0, 0, 0, 8'h00);
    rx_en <= 1'b1;
    frame(16'h0105, 1, 0, 1, 8'h02);
    frame(16'h0105, 2, 0, 1, 8'h01);
    exp_q = '{-1, -1};
    // fill the word buffer to its depth, then one more is refused
    for (int i = 0; i < 30; i++) begin
      w = (i == 0) ? 16'h0105 : 16'($random(seed));
      frame(w, 0, 1, 0, 8'h00);
      exp_q.push_back(int'(w));
    end
    frame(16'($random(seed)), 0, 0, 0, 8'h00);
    while (exp_q.size() > 0) begin
      e = exp_q.pop_front();
      chk("rx valid", 16'h1, {15'h0, rxv});
      if (e >= 0) chk("rx word", e[15:0], word);
      @(posedge mclk_in) rd <= 1'b1;
      @(posedge mclk_in) rd <= 1'b0;
      #1;
    end
    chk("rx empty", 16'h0, {15'h0, rxv});
    // echo would corrupt reception, so receive is off while sending
    rx_en <= 1'b0;
    tx_en <= 1'b1;
    @(posedge mclk_in);
    send_tx(8'h00);
    send_tx(8'hff);
    for (int i = 0; i < 2; i++) send_tx(8'($random(seed)));
    // abort mid-frame, then a write while disabled is ignored
    e = n_txd;
    @(posedge mclk_in) wr <= 1'b1;
    @(posedge mclk_in) wr <= 1'b0;
    repeat (3 * HALF) @(posedge mclk_in);
    tx_en <= 1'b0;
    repeat (3) @(posedge mclk_in);
    wr <= 1'b1;
    @(posedge mclk_in) wr <= 1'b0;
    repeat (2) @(posedge mclk_in);
    #1 chk("tx abort pin", 16'h1, {15'h0, tx_pin});
    chk("tx abort busy", 16'h0, {15'h0, busy});
    chk("tx abort done", e[15:0], 16'(n_txd));
    // clock enable goes last, pin must stay idle
    clk_en <= 1'b0;
    repeat (2) @(posedge mclk_in);
    #1 chk("tx off pin", 16'h1, {15'h0, tx_pin});
    end_sim();
  end
endmodule // dssu_serial_unit_bench
